// ---- test/core_seq_model.sv ----
// Purpose: Core sequencer stand-in that accepts grant offers
// Assumes: take_en is a level from the bench on sys_clk
// Notes: One take per raised take_en; the bench drops take_en on seeing the pulse
`timescale 1ns/1ps
`default_nettype none

module core_seq_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic take_en,
	input wire logic grant_valid,
	input wire logic [3:0] grant_vector,
	output logic grant_take,
	output logic [3:0] last_vec
);
	////////////////////////////////////////////////////////////////////////////////
	// Takes only while an offer stands and never twice in a row, so a slow bench
	// cannot turn one acceptance into two
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			grant_take <= 1'b0;
			last_vec <= 4'h0;
		end else begin
			grant_take <= take_en && grant_valid && !grant_take;
			if (take_en && grant_valid && !grant_take) begin
				last_vec <= grant_vector;
			end
		end
	end
endmodule : core_seq_model

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Register, gating and grant checks of the priority/enable bank
// Assumes: Wishbone classic master, one request at a time
// Notes: Outputs are read just after an edge, so they show the settled pre-edge value
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.svh"

module tb_top;
	import irq_bank_pkg::*;
	`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
		$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
	localparam int PMAP [11] = '{7, 8, 9, 10, 11, 12, 12, 13, 13, 14, 14};
	logic sys_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, take_en, service_done, grant_take;
	logic [9:0] wb_adr;
	logic [31:0] wb_dat_w, wb_dat_r, rdat;
	logic [3:0] wb_sel, grant_vector, last_vec;
	logic [6:0] base_req;
	logic [10:0] src;
	logic [14:0] req_pending, prio_level;
	logic [7:0] ext_enable, e;
	logic grant_valid, grant_high, service_high, service_low, irq;
	int miscompares, n_checks;
	////////////////////////////////////////////////////////////////////////////////
	irq_priority_enable_bank #(.ADR_W(10)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.base_req(base_req), .smbus_req(src[0]), .clock_alarm_req(src[1]),
		.window_compare_flag(src[2]), .conversion_done_flag(src[3]),
		.counter_array_req(src[4]), .comparator0_rise_flag(src[5]),
		.comparator0_fall_flag(src[6]), .comparator1_rise_flag(src[7]),
		.comparator1_fall_flag(src[8]), .timer3_low_overflow_flag(src[9]),
		.timer3_high_overflow_flag(src[10]), .grant_take(grant_take),
		.service_done(service_done), .req_pending(req_pending), .prio_level(prio_level),
		.ext_enable(ext_enable), .grant_valid(grant_valid), .grant_high(grant_high),
		.grant_vector(grant_vector), .service_high(service_high),
		.service_low(service_low), .irq(irq));
	core_seq_model core (.sys_clk(sys_clk), .resetn(resetn), .take_en(take_en),
		.grant_valid(grant_valid), .grant_vector(grant_vector), .grant_take(grant_take),
		.last_vec(last_vec));
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic we, input logic [7:0] i, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {i, 2'b00};
		wb_dat_w <= {24'h000000, d};
		wb_sel <= s;
		do @(posedge sys_clk); while (wb_ack !== 1'b1);
		rdat = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, i, d, 4'h1);
	endtask : wr
	task automatic rd_chk(input logic [7:0] i, input logic [7:0] x);
		bus(1'b0, i, 8'h00, 4'h1);
		`CHK(rdat, {24'h000000, x});
	endtask : rd_chk
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : w
	task automatic take(input logic [3:0] v);
		take_en <= 1'b1;
		do @(posedge sys_clk); while (grant_take !== 1'b1);
		take_en <= 1'b0;
		`CHK(last_vec, v);
	endtask : take
	task automatic done();
		@(posedge sys_clk);
		service_done <= 1'b1;
		@(posedge sys_clk);
		service_done <= 1'b0;
	endtask : done
	task end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	// The whole run takes well under 2000 cycles; a hang ends it here
	initial begin
		#3000000;
		miscompares++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_clk, resetn, wb_cyc, wb_stb, wb_we, take_en, service_done} = 7'h00;
		{wb_adr, wb_dat_w, wb_sel, base_req, src} = '0;
		w(6);
		resetn <= 1'b1;
		rd_chk(`BASE_PRIO_IDX, 8'h80);
		rd_chk(`EXT_EN1_IDX, 8'h00);
		rd_chk(`EXT_PRIO1_IDX, 8'h00);
		rd_chk(8'h40, 8'h00);
		wr(`BASE_PRIO_IDX, 8'h55);
		rd_chk(`BASE_PRIO_IDX, 8'hd5);
		`CHK(prio_level[6:0], 7'h55);
		wr(`BITOP_IDX, 8'h09);
		rd_chk(`BASE_PRIO_IDX, 8'hd7);
		wr(`BITOP_IDX, 8'h04);
		wr(`BITOP_IDX, 8'h07);
		rd_chk(`BASE_PRIO_IDX, 8'hc7);
		$display("test base priority done");
		wr(`PAGE_IDX, 8'h01);
		rd_chk(`PAGE_IDX, 8'h01);
		rd_chk(`BASE_PRIO_IDX, 8'h00);
		wr(`BASE_PRIO_IDX, 8'h3a);
		wr(`EXT_EN1_IDX, 8'ha5);
		bus(1'b1, `EXT_EN1_IDX, 8'h00, 4'h0);
		rd_chk(`EXT_EN1_IDX, 8'ha5);
		wr(`EXT_PRIO1_IDX, 8'h3c);
		rd_chk(`EXT_PRIO1_IDX, 8'h3c);
		`CHK(prio_level[14:7], 8'h3c);
		`CHK(ext_enable, 8'ha5);
		wr(`PAGE_IDX, 8'h00);
		rd_chk(`BASE_PRIO_IDX, 8'hc7);
		$display("test paging done");
		wr(`CTRL_IDX, 8'h01);
		rd_chk(`CTRL_IDX, 8'h01);
		for (int s = 0; s < 11; s++) begin
			e = 8'h01 << (PMAP[s] - 7);
			wr(`EXT_EN1_IDX, ~e);
			src <= 11'h001 << s;
			w(3);
			`CHK(req_pending, 15'h0000);
			wr(`EXT_EN1_IDX, e);
			w(3);
			`CHK(req_pending, 15'h0001 << PMAP[s]);
		end
		wr(`EXT_EN1_IDX, 8'hff);
		wr(`CTRL_IDX, 8'h00);
		src <= 11'h7ff;
		base_req <= 7'h7f;
		w(3);
		`CHK(req_pending, 15'h0000);
		wr(`CTRL_IDX, 8'h01);
		w(3);
		`CHK(req_pending, 15'h7fff);
		src <= 11'h000;
		base_req <= 7'h06;
		$display("test gating done");
		wr(`BASE_PRIO_IDX, 8'h00);
		wr(`EXT_PRIO1_IDX, 8'h00);
		wr(`EVT_MASK_IDX, 8'h07);
		w(4);
		`CHK({grant_valid, grant_high, grant_vector}, 6'h21);
		take(4'h1);
		w(3);
		`CHK({service_high, service_low, grant_valid, irq}, 4'h5);
		wr(`EXT_PRIO1_IDX, 8'h01);
		src <= 11'h001;
		w(4);
		`CHK({grant_valid, grant_high, grant_vector}, 6'h37);
		take(4'h7);
		w(3);
		`CHK({service_high, service_low, grant_valid}, 3'h6);
		rd_chk(`EVT_STAT_IDX, 8'h07);
		wr(`EVT_MASK_IDX, 8'h00);
		w(3);
		`CHK(irq, 1'b0);
		wr(`EVT_MASK_IDX, 8'h07);
		w(3);
		`CHK(irq, 1'b1);
		wr(`EVT_STAT_IDX, 8'h07);
		w(3);
		`CHK(irq, 1'b0);
		rd_chk(`EVT_STAT_IDX, 8'h00);
		src <= 11'h000;
		done();
		w(3);
		`CHK({service_high, service_low}, 2'h1);
		done();
		w(3);
		`CHK({service_low, grant_valid, grant_vector}, 6'h11);
		rd_chk(`SVC_IDX, 8'h11);
		$display("test grants done");
		end_sim();
	end
endmodule : tb_top

`default_nettype wire

// ---- verilog/irq_bank_consts.svh ----
// Purpose: Offsets, reset values and field positions of the priority/enable bank
// Assumes: Register index = SFR address; Wishbone byte address = 4 * index
// Notes: Definitions only
`ifndef IRQ_BANK_CONSTS_SVH
`define IRQ_BANK_CONSTS_SVH

`define BASE_PRIO_IDX 8'hb8
`define EXT_EN1_IDX 8'he6
`define EXT_PRIO1_IDX 8'hf6
`define PAGE_IDX 8'h00
`define CTRL_IDX 8'h01
`define BITOP_IDX 8'h02
`define EVT_STAT_IDX 8'h03
`define EVT_MASK_IDX 8'h04
`define SVC_IDX 8'h05

`define BASE_PRIO_PAGE 8'h00
`define BASE_PRIO_RST 8'h80
`define BASE_PRIO_WMASK 8'h7f
`define EXT_RST 8'h00
`define EXT_WMASK 8'hff
`define OWN_RST 8'h00

`define CTRL_GATE_BIT 0
`define BITOP_VAL_BIT 3
`define EVT_LOW_BIT 0
`define EVT_HIGH_BIT 1
`define EVT_PREEMPT_BIT 2

`endif

// ---- verilog/irq_bank_pkg.sv ----
// Purpose: Types shared by the priority/enable bank
// Assumes: Fifteen request sources, vector positions 0 to 14
// Notes: Constants live in irq_bank_consts.svh
package irq_bank_pkg;

	localparam int NUM_SRC = 15;
	localparam int VEC_W = 4;

	typedef enum logic [0:0] {
		GR_IDLE,
		GR_OFFER
	} grant_e;

	typedef struct packed {
		logic [7:0] value;
	} sfr_state_s;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [7:0] page;
		logic gate;
		logic [2:0] evt_stat;
		logic [2:0] evt_mask;
		logic irq;
		logic [14:0] pending;
		logic [14:0] prio;
		grant_e gstate;
		logic grant_high;
		logic [3:0] grant_vec;
		logic act_high;
		logic act_low;
	} top_state_s;

endpackage : irq_bank_pkg

// ---- verilog/irq_priority_enable_bank.sv ----
// Purpose: Priority and extended enable registers, request gating and level ranking
// Assumes: Request flags come from logic on sys_clk; Wishbone classic slave, 8-bit data
// Notes: Byte address is four times the SFR index; only byte lane 0 is writable
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.svh"

module irq_priority_enable_bank
	import irq_bank_pkg::*;
#(
	parameter int ADR_W = 10
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [ADR_W-1:0] wb_adr,
	input wire logic [31:0] wb_dat_w,
	input wire logic [3:0] wb_sel,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [6:0] base_req,
	input wire logic timer3_low_overflow_flag,
	input wire logic timer3_high_overflow_flag,
	input wire logic comparator1_rise_flag,
	input wire logic comparator1_fall_flag,
	input wire logic comparator0_rise_flag,
	input wire logic comparator0_fall_flag,
	input wire logic counter_array_req,
	input wire logic conversion_done_flag,
	input wire logic window_compare_flag,
	input wire logic clock_alarm_req,
	input wire logic smbus_req,
	input wire logic grant_take,
	input wire logic service_done,
	output logic [14:0] req_pending,
	output logic [14:0] prio_level,
	output logic [7:0] ext_enable,
	output logic grant_valid,
	output logic grant_high,
	output logic [3:0] grant_vector,
	output logic service_high,
	output logic service_low,
	output logic irq
);

	if (ADR_W < 10) begin : g_adr_check
		$error("address bus must reach index 0xff");
	end

	////////////////////////////////////////////////////////////////////////
	top_state_s s_reg;
	top_state_s s_next;

	logic [7:0] idx;
	logic req_new;
	logic commit;
	logic page_ok;
	logic [7:0] base_prio_q;
	logic [7:0] ext_en_q;
	logic [7:0] ext_prio_q;
	logic [7:0] wdata;
	logic [14:0] raw_req;
	logic [14:0] en_vec;
	logic [14:0] hi_cand;
	logic [14:0] lo_cand;
	logic hi_found;
	logic lo_found;
	logic [3:0] hi_idx;
	logic [3:0] lo_idx;

	assign idx = wb_adr[9:2];
	assign wdata = wb_dat_w[7:0];
	assign req_new = wb_cyc && wb_stb && !s_reg.ack;
	// Writes land on the edge where the master sees ack, never earlier
	assign commit = wb_cyc && wb_stb && wb_we && s_reg.ack && wb_sel[0];
	assign page_ok = (s_reg.page == `BASE_PRIO_PAGE);

	////////////////////////////////////////////////////////////////////////
	sfr_bit_reg #(.W(8), .RST(`BASE_PRIO_RST), .WMASK(`BASE_PRIO_WMASK)) u_base_prio (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wr_en(commit && idx == `BASE_PRIO_IDX && page_ok),
		.wr_data(wdata),
		.bit_en(commit && idx == `BITOP_IDX && page_ok),
		.bit_idx(wdata[2:0]),
		.bit_val(wdata[`BITOP_VAL_BIT]),
		.q(base_prio_q)
	);

	sfr_bit_reg #(.W(8), .RST(`EXT_RST), .WMASK(`EXT_WMASK)) u_ext_en (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wr_en(commit && idx == `EXT_EN1_IDX),
		.wr_data(wdata),
		.bit_en(1'b0),
		.bit_idx(3'h0),
		.bit_val(1'b0),
		.q(ext_en_q)
	);

	sfr_bit_reg #(.W(8), .RST(`EXT_RST), .WMASK(`EXT_WMASK)) u_ext_prio (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wr_en(commit && idx == `EXT_PRIO1_IDX),
		.wr_data(wdata),
		.bit_en(1'b0),
		.bit_idx(3'h0),
		.bit_val(1'b0),
		.q(ext_prio_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Vector order: base sources 0..6, then SMBus 7 up to timer 3 at 14
	assign raw_req = {
		timer3_low_overflow_flag || timer3_high_overflow_flag,
		comparator1_rise_flag || comparator1_fall_flag,
		comparator0_rise_flag || comparator0_fall_flag,
		counter_array_req,
		conversion_done_flag,
		window_compare_flag,
		clock_alarm_req,
		smbus_req,
		base_req
	};
	// Base enables sit outside this bank, so base requests arrive pre-masked
	assign en_vec = {ext_en_q, 7'h7f};

	assign hi_cand = s_reg.pending & s_reg.prio;
	assign lo_cand = s_reg.pending & ~s_reg.prio;

	lowest_pick #(.N(NUM_SRC), .IDX_W(VEC_W)) u_pick_hi (
		.vec(hi_cand),
		.found(hi_found),
		.idx(hi_idx)
	);

	lowest_pick #(.N(NUM_SRC), .IDX_W(VEC_W)) u_pick_lo (
		.vec(lo_cand),
		.found(lo_found),
		.idx(lo_idx)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic taken;
		logic [2:0] evt_set;
		taken = 1'b0;
		evt_set = 3'h0;
		s_next = s_reg;
		s_next.ack = req_new;
		if (req_new) begin
			s_next.rdata = 8'h00;
			if (idx == `BASE_PRIO_IDX) begin
				s_next.rdata = page_ok ? base_prio_q : 8'h00;
			end else if (idx == `EXT_EN1_IDX) begin
				s_next.rdata = ext_en_q;
			end else if (idx == `EXT_PRIO1_IDX) begin
				s_next.rdata = ext_prio_q;
			end else if (idx == `PAGE_IDX) begin
				s_next.rdata = s_reg.page;
			end else if (idx == `CTRL_IDX) begin
				s_next.rdata = {7'h00, s_reg.gate};
			end else if (idx == `EVT_STAT_IDX) begin
				s_next.rdata = {5'h00, s_reg.evt_stat};
			end else if (idx == `EVT_MASK_IDX) begin
				s_next.rdata = {5'h00, s_reg.evt_mask};
			end else if (idx == `SVC_IDX) begin
				s_next.rdata = {s_reg.grant_vec, s_reg.act_high, s_reg.act_low,
					s_reg.grant_high, s_reg.gstate == GR_OFFER};
			end
		end
		if (commit) begin
			if (idx == `PAGE_IDX) begin
				s_next.page = wdata;
			end else if (idx == `CTRL_IDX) begin
				s_next.gate = wdata[`CTRL_GATE_BIT];
			end else if (idx == `EVT_MASK_IDX) begin
				s_next.evt_mask = wdata[2:0];
			end
		end

		// Gate and enable are applied to the live flags each cycle
		s_next.pending = raw_req & en_vec & {NUM_SRC{s_reg.gate}};
		s_next.prio = {ext_prio_q, base_prio_q[6:0]};

		// A return ends the innermost level, which is high if both are open
		if (service_done) begin
			if (s_reg.act_high) begin
				s_next.act_high = 1'b0;
			end else begin
				s_next.act_low = 1'b0;
			end
		end
		taken = grant_take && s_reg.gstate == GR_OFFER;
		if (taken) begin
			if (s_reg.grant_high) begin
				s_next.act_high = 1'b1;
				evt_set[`EVT_HIGH_BIT] = 1'b1;
				evt_set[`EVT_PREEMPT_BIT] = s_next.act_low;
			end else begin
				s_next.act_low = 1'b1;
				evt_set[`EVT_LOW_BIT] = 1'b1;
			end
		end

		case (s_reg.gstate)
			GR_IDLE, GR_OFFER: begin
				s_next.gstate = GR_IDLE;
				if (hi_found && !s_next.act_high) begin
					s_next.gstate = GR_OFFER;
					s_next.grant_high = 1'b1;
					s_next.grant_vec = hi_idx;
				end else if (lo_found && !s_next.act_high && !s_next.act_low) begin
					s_next.gstate = GR_OFFER;
					s_next.grant_high = 1'b0;
					s_next.grant_vec = lo_idx;
				end
			end
			default: s_next.gstate = GR_IDLE;
		endcase

		// Set beats a same-cycle write-one clear so no event is lost
		s_next.evt_stat = s_reg.evt_stat;
		if (commit && idx == `EVT_STAT_IDX) begin
			s_next.evt_stat = s_reg.evt_stat & ~wdata[2:0];
		end
		s_next.evt_stat = s_next.evt_stat | evt_set;
		s_next.irq = |(s_next.evt_stat & s_next.evt_mask);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{ack: 1'b0, rdata: `OWN_RST, page: `OWN_RST, gate: 1'b0,
				evt_stat: 3'h0, evt_mask: 3'h0, irq: 1'b0, pending: 15'h0000,
				prio: 15'h0000, gstate: GR_IDLE, grant_high: 1'b0, grant_vec: 4'h0,
				act_high: 1'b0, act_low: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign wb_ack = s_reg.ack;
	assign wb_dat_r = {24'h000000, s_reg.rdata};
	assign req_pending = s_reg.pending;
	assign prio_level = s_reg.prio;
	assign ext_enable = ext_en_q;
	assign grant_valid = (s_reg.gstate == GR_OFFER);
	assign grant_high = s_reg.grant_high;
	assign grant_vector = s_reg.grant_vec;
	assign service_high = s_reg.act_high;
	assign service_low = s_reg.act_low;
	assign irq = s_reg.irq;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic [14:0] below_mask;
	assign below_mask = 15'((16'h0001 << s_reg.grant_vec) - 16'h0001);

	sequence s_bus_req;
		wb_cyc && wb_stb && !wb_ack;
	endsequence
	sequence s_bus_ans;
		wb_ack ##1 !wb_ack;
	endsequence
	a_bus_ack_once: assert property (s_bus_req |=> s_bus_ans)
		else $error("ack not one cycle after request");

	a_base_page_read: assert property (wb_ack && !wb_we && idx == `BASE_PRIO_IDX
		|-> wb_dat_r[7:0] == ($past(page_ok) ? {1'b1, base_prio_q[6:0]} : 8'h00))
		else $error("base priority read ignores page");
	a_ext_en_read: assert property (wb_ack && !wb_we && idx == `EXT_EN1_IDX
		|-> wb_dat_r[7:0] == $past(ext_en_q)) else $error("enable read wrong");
	a_ext_prio_read: assert property (wb_ack && !wb_we && idx == `EXT_PRIO1_IDX
		|-> wb_dat_r[7:0] == $past(ext_prio_q)) else $error("priority read wrong");
	a_timer3_gate: assert property (1'b1 |=> req_pending[14] ==
		($past(s_reg.gate) && $past(ext_en_q[7]) &&
		($past(timer3_low_overflow_flag) || $past(timer3_high_overflow_flag))))
		else $error("timer 3 gating wrong");
	a_cmp_gates: assert property (1'b1 |=>
		req_pending[13] == ($past(s_reg.gate) && $past(ext_en_q[6]) &&
		($past(comparator1_rise_flag) || $past(comparator1_fall_flag))) &&
		req_pending[12] == ($past(s_reg.gate) && $past(ext_en_q[5]) &&
		($past(comparator0_rise_flag) || $past(comparator0_fall_flag))))
		else $error("comparator gating");
	a_unit_gates: assert property (1'b1 |=>
		req_pending[11] == ($past(s_reg.gate) && $past(ext_en_q[4]) &&
		$past(counter_array_req)) &&
		req_pending[7] == ($past(s_reg.gate) && $past(ext_en_q[0]) && $past(smbus_req)))
		else $error("unit gating wrong");
	a_conv_gate: assert property (1'b1 |=>
		req_pending[10] == ($past(s_reg.gate) && $past(ext_en_q[3]) &&
		$past(conversion_done_flag))) else $error("conversion gating wrong");
	a_window_gate: assert property (1'b1 |=>
		req_pending[9] == ($past(s_reg.gate) && $past(ext_en_q[2]) &&
		$past(window_compare_flag))) else $error("window gating wrong");
	a_alarm_gate: assert property (1'b1 |=>
		req_pending[8] == ($past(s_reg.gate) && $past(ext_en_q[1]) &&
		$past(clock_alarm_req))) else $error("alarm gating wrong");
	a_prio_levels: assert property (1'b1 |=>
		prio_level == {$past(ext_prio_q), $past(base_prio_q[6:0])}) else $error("levels wrong");
	a_global_gate: assert property (!s_reg.gate |=> req_pending == 15'h0000)
		else $error("request passed closed gate");
	a_high_blocked: assert property (grant_valid && grant_high |-> !service_high)
		else $error("high offered inside high service");
	a_low_waits: assert property (grant_valid && !grant_high
		|-> !service_high && !service_low) else $error("low offered during service");
	a_lowest_first: assert property (grant_valid && grant_high |->
		($past(hi_cand) & below_mask) == 15'h0000) else $error("tie not lowest");

endmodule : irq_priority_enable_bank
`default_nettype wire

// ---- verilog/lowest_pick.sv ----
// Purpose: Finds the lowest set position of a request vector
// Assumes: Purely combinational
// Notes: Lowest position wins so ties resolve toward the lower vector
`timescale 1ns/1ps
`default_nettype none

module lowest_pick #(
	parameter int N = 15,
	parameter int IDX_W = 4
) (
	input wire logic [N-1:0] vec,
	output logic found,
	output logic [IDX_W-1:0] idx
);

	if (N > (1 << IDX_W) || N < 1) begin : g_size_check
		$error("lowest_pick index too narrow for N");
	end

	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (vec[i]) begin
				found = 1'b1;
				idx = IDX_W'(i);
			end
		end
	end

endmodule : lowest_pick
`default_nettype wire

// ---- verilog/sfr_bit_reg.sv ----
// Purpose: One 8-bit special-function register with whole and single-bit writes
// Assumes: Write and bit strobes are one-cycle and on sys_clk
// Notes: Bits outside the write mask stay at their reset value
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.svh"

module sfr_bit_reg
	import irq_bank_pkg::*;
#(
	parameter int W = 8,
	parameter logic [7:0] RST = `EXT_RST,
	parameter logic [7:0] WMASK = `EXT_WMASK
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic bit_en,
	input wire logic [2:0] bit_idx,
	input wire logic bit_val,
	output logic [7:0] q
);

	if (W != 8) begin : g_width_check
		$error("sfr_bit_reg serves 8-bit registers only");
	end

	sfr_state_s s_reg;
	sfr_state_s s_next;

	always_comb begin
		s_next = s_reg;
		if (wr_en) begin
			s_next.value = (s_reg.value & ~WMASK) | (wr_data & WMASK);
		end else if (bit_en && WMASK[bit_idx]) begin
			s_next.value[bit_idx] = bit_val;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg.value <= RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.value;

	a_fixed_bits_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		(q & ~WMASK) == (RST & ~WMASK)) else $error("fixed bit changed");

	a_write_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_en |=> (q & WMASK) == ($past(wr_data) & WMASK)) else $error("write lost");

endmodule : sfr_bit_reg
`default_nettype wire
